// >>> verilog/secured_otp_ctrl.sv
// otp mode, security flags and discovery read logic behind the serial front end
`timescale 1ns/1ps
// Contract
// R1 - instruction b1h puts the device into the 4k-bit otp area mode
// R2 - instruction c1h returns the device to main-array operation
// R3 - in otp mode ordinary reads and page programs target the otp area
// R4 - in otp mode status-1, status-2 and security writes are rejected
// R5 - once locked, otp program and erase attempts are ignored
// R6 - in otp mode every main-array write is blocked
// R7 - security register readable any time, repeated while clocks continue
// R8 - bit 0 is read-only factory lock indicator
// R9 - bit 1 customer lock, set only by security write, then frozen
// R10 - discovery byte 81h reads 20h
// R11 - discovery byte 82h reads f1h
// R12 - bytes 84h to 86h read ffh, byte 87h reads 03h
// R13 - byte 88h reads 44h, byte 89h reads ebh
// R14 - bytes 8ah/8ch read 08h, 8bh reads 6bh, 8dh reads 3bh
// R15 - byte 8eh reads 80h, byte 8fh reads bbh
// R16 - 90h reads feh, 96h 00h, 9ah 44h, 9bh ebh
// R17 - bytes 9ch to a3h read 0c 20 0f 52 10 d8 00 ff
// R18 - reserved discovery bytes read ffh
// R19 - discovery read is opcode, 24-bit address, dummy, then bytes until deselect
// R20 - security bits 7 to 2 are reserved and ignore writes
module secured_otp_ctrl #(
    parameter logic [7:0] OP_WRITE_SR1 = 8'h01,
    parameter logic [7:0] OP_WRITE_SR2 = 8'h31
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire logic OPCODE_VALID_I,
    input wire logic [7:0] OPCODE_I,
    input wire logic ADDR_VALID_I,
    input wire logic [23:0] ADDR_I,
    input wire logic WDATA_VALID_I,
    input wire logic [7:0] WDATA_I,
    input wire logic BYTE_REQ_I,
    input wire logic FRAME_END_I,
    input wire logic BOUNDARY_OK_I,
    input wire logic WRITE_REQ_I,
    input wire logic FACTORY_LOCK_I,
    input wire logic NV_LOCK_I,
    output logic OTP_MODE_O,
    output logic ARRAY_WRITE_EN_O,
    output logic OTP_WRITE_EN_O,
    output logic WRITE_ACCEPT_O,
    output logic WRITE_DENY_O,
    output logic SR_WRITE_GO_O,
    output logic CMD_REJECT_O,
    output logic NV_LOCK_PROG_O,
    output logic [7:0] SEC_REG_O,
    output logic [7:0] TX_BYTE_O,
    output logic TX_VALID_O
);
    import otp_sfdp_pkg::*;

    frame_state_t state;
    frame_state_t next_state;
    logic [7:0] cur_op;
    logic otp_mode;
    logic loaded;
    logic factory_lock;
    logic cust_lock;
    logic [23:0] disc_addr;
    logic [7:0] wdata;
    logic [3:0] wcount;
    logic cust_seen;
    logic [3:0] sec_streak;

    function automatic logic is_sr_write(input logic [7:0] op);
        return (op == OP_WRITE_SR1) || (op == OP_WRITE_SR2) || (op == OP_WRITE_SEC);
    endfunction : is_sr_write

    wire [7:0] sec_value = {6'h00, cust_lock, factory_lock}; // [R8] [R20]
    wire locked = cust_lock | factory_lock;
    wire frame_done = FRAME_END_I && (state != ST_IDLE);
    wire do_enter = frame_done && (cur_op == OP_ENTER_OTP);
    wire do_leave = frame_done && (cur_op == OP_LEAVE_OTP);
    wire sr_cmd = frame_done && is_sr_write(cur_op);
    wire sr_reject = sr_cmd && otp_mode; // [R4]
    wire sec_exec = sr_cmd && !otp_mode && (cur_op == OP_WRITE_SEC)
                    && BOUNDARY_OK_I && (wcount == 4'h1);
    wire lock_set = sec_exec && wdata[SEC_LOCK_BIT] && !cust_lock; // [R9]
    wire sr_go = sr_cmd && !otp_mode && (cur_op != OP_WRITE_SEC);
    wire rd_sec = BYTE_REQ_I && (state != ST_IDLE) && (cur_op == OP_READ_SEC);
    wire rd_disc = BYTE_REQ_I && (state == ST_DATA) && (cur_op == OP_READ_DISC);
    wire [7:0] disc_byte;

    discovery_rom u_rom (
        .addr_i(disc_addr),
        .data_o(disc_byte)
    );

    // frame sequencing: opcode, then address or data, ended by deselect
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (OPCODE_VALID_I) begin
                    next_state = ST_OPCODE;
                end
            end
            ST_OPCODE: begin
                if (FRAME_END_I) begin
                    next_state = ST_IDLE;
                end else if (ADDR_VALID_I || WDATA_VALID_I) begin
                    next_state = ST_DATA;
                end
            end
            ST_DATA: begin
                if (FRAME_END_I) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            state <= ST_IDLE;
            cur_op <= 8'h00;
        end else begin
            state <= next_state;
            if (OPCODE_VALID_I && state == ST_IDLE) begin
                cur_op <= OPCODE_I;
            end
        end
    end

    // otp mode flag
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            otp_mode <= 1'b0;
        end else if (do_enter) begin
            otp_mode <= 1'b1; // [R1]
        end else if (do_leave) begin
            otp_mode <= 1'b0; // [R2]
        end
    end

    // non-volatile lock bits are loaded once after reset release
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            loaded <= 1'b0;
            factory_lock <= 1'b0;
            cust_lock <= 1'b0;
        end else if (!loaded) begin
            loaded <= 1'b1;
            factory_lock <= FACTORY_LOCK_I; // [R8]
            cust_lock <= NV_LOCK_I;
        end else if (lock_set) begin
            cust_lock <= 1'b1; // [R9]
        end
    end

    // write data byte and count for the security write
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            wdata <= 8'h00;
            wcount <= 4'h0;
        end else if (state == ST_IDLE) begin
            wcount <= 4'h0;
        end else if (WDATA_VALID_I) begin
            wdata <= WDATA_I;
            if (wcount != 4'hf) begin
                wcount <= wcount + 4'h1;
            end
        end
    end

    // discovery address pointer
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            disc_addr <= 24'h000000;
        end else if (ADDR_VALID_I && state == ST_OPCODE) begin
            disc_addr <= ADDR_I; // [R19]
        end else if (rd_disc) begin
            disc_addr <= disc_addr + 24'h000001; // [R19]
        end
    end

    // byte output for security and discovery reads
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            TX_BYTE_O <= 8'h00;
            TX_VALID_O <= 1'b0;
        end else begin
            TX_VALID_O <= rd_sec | rd_disc;
            if (rd_sec) begin
                TX_BYTE_O <= sec_value; // [R7]
            end else if (rd_disc) begin
                TX_BYTE_O <= disc_byte; // [R19]
            end
        end
    end

    // write gating and command outcome pulses
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            WRITE_ACCEPT_O <= 1'b0;
            WRITE_DENY_O <= 1'b0;
            SR_WRITE_GO_O <= 1'b0;
            CMD_REJECT_O <= 1'b0;
            NV_LOCK_PROG_O <= 1'b0;
            SEC_REG_O <= SEC_RESET;
        end else begin
            WRITE_ACCEPT_O <= WRITE_REQ_I && !(otp_mode && locked); // [R5]
            WRITE_DENY_O <= WRITE_REQ_I && otp_mode && locked; // [R5]
            SR_WRITE_GO_O <= sr_go;
            CMD_REJECT_O <= sr_reject; // [R4]
            NV_LOCK_PROG_O <= lock_set;
            SEC_REG_O <= sec_value;
        end
    end

    assign OTP_MODE_O = otp_mode; // [R3]
    assign ARRAY_WRITE_EN_O = !otp_mode; // [R6]
    assign OTP_WRITE_EN_O = otp_mode && !locked; // [R5]

    // assertion helpers: lock history and security read streak per frame
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_N_I) begin
            cust_seen <= 1'b0;
            sec_streak <= 4'h0;
        end else begin
            cust_seen <= cust_seen | (loaded & cust_lock);
            if (state == ST_IDLE) begin
                sec_streak <= 4'h0;
            end else if (rd_sec && sec_streak != 4'hf) begin
                sec_streak <= sec_streak + 4'h1;
            end
        end
    end

    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    chk_enter_sets_mode: assert property (do_enter |=> otp_mode) // [R1]
        else $error("enter did not set otp mode");
    chk_mode_only_enter: assert property (!do_enter && !otp_mode |=> !otp_mode) // [R1]
        else $error("otp mode set without enter");
    chk_leave_clears_mode: assert property (do_leave |=> !otp_mode) // [R2]
        else $error("leave did not clear otp mode");
    chk_mode_only_leave: assert property (!do_leave && otp_mode |=> otp_mode) // [R2]
        else $error("otp mode left without leave");
    chk_otp_routes_target: assert property (otp_mode && !do_leave |=> OTP_MODE_O) // [R3]
        else $error("otp routing dropped");
    chk_sr_write_reject: assert property (sr_cmd && otp_mode |=> // [R4]
        CMD_REJECT_O && !SR_WRITE_GO_O && $stable(cust_lock))
        else $error("status write not rejected in otp mode");
    chk_sr_go_outside: assert property (sr_cmd && !otp_mode && (cur_op != OP_WRITE_SEC) |=> // [R4]
        SR_WRITE_GO_O && !CMD_REJECT_O)
        else $error("status write not passed outside otp mode");
    chk_reject_no_exec: assert property (sr_reject |-> !lock_set && !sr_go) // [R4]
        else $error("rejected write still executed");
    chk_locked_write_deny: assert property (WRITE_REQ_I && otp_mode && locked |=> // [R5]
        WRITE_DENY_O && !WRITE_ACCEPT_O)
        else $error("locked otp write not denied");
    chk_write_accept_open: assert property (WRITE_REQ_I && !(otp_mode && locked) |=> // [R5]
        WRITE_ACCEPT_O && !WRITE_DENY_O)
        else $error("allowed write not accepted");
    chk_deny_only_locked: assert property (WRITE_DENY_O |-> $past(otp_mode) && $past(locked)) // [R5]
        else $error("write denied while not locked");
    chk_otp_write_lock: assert property (locked |-> !OTP_WRITE_EN_O) // [R5]
        else $error("otp write open while locked");
    chk_array_write_block: assert property (otp_mode |-> !ARRAY_WRITE_EN_O) // [R6]
        else $error("array write open in otp mode");
    chk_sec_read_value: assert property (rd_sec |=> TX_VALID_O && // [R7]
        TX_BYTE_O == {6'h00, $past(cust_lock), $past(factory_lock)})
        else $error("security read value wrong");
    chk_lock_sticky: assert property (loaded && cust_lock |=> cust_lock) // [R9]
        else $error("customer lock cleared");
    chk_lock_history: assert property (cust_seen |-> cust_lock) // [R9]
        else $error("customer lock lost after being seen");
    chk_lock_only_by_write: assert property (loaded && !cust_lock && !lock_set |=> !cust_lock) // [R9]
        else $error("customer lock set without security write");
    chk_short_sec_write: assert property (sr_cmd && !BOUNDARY_OK_I |=> !NV_LOCK_PROG_O) // [R9]
        else $error("lock programmed off a byte boundary");
    chk_sec_write_once: assert property (sr_cmd && (wcount != 4'h1) |=> !NV_LOCK_PROG_O) // [R9]
        else $error("lock programmed with wrong byte count");
    chk_lock_prog_pulse: assert property (NV_LOCK_PROG_O |=> !NV_LOCK_PROG_O) // [R9]
        else $error("lock program pulse repeated");
    chk_factory_stable: assert property (loaded |=> $stable(factory_lock)) // [R8]
        else $error("factory lock changed");
    chk_sec_reg_track: assert property (loaded |=> SEC_REG_O == $past(sec_value)) // [R8]
        else $error("security register output stale");
    chk_reserved_zero: assert property (SEC_REG_O[7:2] == 6'h00) // [R20]
        else $error("reserved security bits set");
    chk_tx_reserved_zero: assert property (rd_sec |=> TX_BYTE_O[7:2] == 6'h00) // [R20]
        else $error("reserved security bits sent");
    chk_disc_addr_step: assert property (rd_disc && !ADDR_VALID_I |=> // [R19]
        disc_addr == $past(disc_addr) + 24'h000001)
        else $error("discovery address did not advance");
    chk_disc_addr_load: assert property (ADDR_VALID_I && state == ST_OPCODE |=> // [R19]
        disc_addr == $past(ADDR_I))
        else $error("discovery address not loaded");
    chk_disc_byte_out: assert property (rd_disc |=> TX_VALID_O && TX_BYTE_O == $past(disc_byte)) // [R19]
        else $error("discovery byte not sent");
    chk_tx_idle_quiet: assert property (!(rd_sec || rd_disc) |=> !TX_VALID_O) // [R19]
        else $error("byte sent without request");

    cov_enter_leave: cover property (do_enter ##[1:50] do_leave);
    cov_lock_set: cover property (lock_set);
    cov_disc_read: cover property (rd_disc ##1 rd_disc);
    cov_sr_reject: cover property (sr_reject);
    cov_sec_repeat: cover property (sec_streak == 4'h2);
endmodule : secured_otp_ctrl

// >>> common/otp_sfdp_pkg.sv
// constants for the secured otp, security flags and discovery table block
package otp_sfdp_pkg;
    localparam logic [7:0] OP_ENTER_OTP = 8'hb1;
    localparam logic [7:0] OP_LEAVE_OTP = 8'hc1;
    localparam logic [7:0] OP_READ_SEC = 8'h2b;
    localparam logic [7:0] OP_WRITE_SEC = 8'h2f;
    localparam logic [7:0] OP_READ_DISC = 8'h5a;
    localparam int SEC_FACTORY_BIT = 0;
    localparam int SEC_LOCK_BIT = 1;
    localparam logic [7:0] SEC_RESET = 8'h00;
    localparam logic [7:0] DISC_BLANK = 8'hff;
    localparam logic [23:0] DISC_LAST_ADDR = 24'h0000ff;
    localparam int OTP_AREA_BITS = 4096;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_OPCODE = 2'b01,
        ST_DATA = 2'b11
    } frame_state_t;
endpackage : otp_sfdp_pkg

// >>> verilog/discovery_rom.sv
// read-only discovery parameter table, bytes 00h to ffh and blank beyond
`timescale 1ns/1ps
module discovery_rom (
    input wire logic [23:0] addr_i,
    output logic [7:0] data_o
);
    import otp_sfdp_pkg::*;

    function automatic logic [7:0] table_byte(input logic [7:0] a);
        logic [7:0] v;
        v = DISC_BLANK; // [R18]
        unique case (a)
            8'h80: v = 8'he5;
            8'h81: v = 8'h20; // [R10]
            8'h82: v = 8'hf1; // [R11]
            8'h87: v = 8'h03; // [R12]
            8'h88: v = 8'h44; // [R13]
            8'h89: v = 8'heb; // [R13]
            8'h8a: v = 8'h08; // [R14]
            8'h8b: v = 8'h6b; // [R14]
            8'h8c: v = 8'h08; // [R14]
            8'h8d: v = 8'h3b; // [R14]
            8'h8e: v = 8'h80; // [R15]
            8'h8f: v = 8'hbb; // [R15]
            8'h90: v = 8'hfe; // [R16]
            8'h96: v = 8'h00; // [R16]
            8'h9a: v = 8'h44; // [R16]
            8'h9b: v = 8'heb; // [R16]
            8'h9c: v = 8'h0c; // [R17]
            8'h9d: v = 8'h20; // [R17]
            8'h9e: v = 8'h0f; // [R17]
            8'h9f: v = 8'h52; // [R17]
            8'ha0: v = 8'h10; // [R17]
            8'ha1: v = 8'hd8; // [R17]
            8'ha2: v = 8'h00; // [R17]
            default: v = DISC_BLANK; // [R12] [R18]
        endcase
        return v;
    endfunction : table_byte

    wire in_table = (addr_i <= DISC_LAST_ADDR);
    assign data_o = in_table ? table_byte(addr_i[7:0]) : DISC_BLANK;
endmodule : discovery_rom

// >>> testbench/host_frontend_model.sv
// host-side serial front end model that issues frames to the otp controller
`timescale 1ns/1ps
module host_frontend_model (
    input wire logic clk_i,
    input wire logic [7:0] tx_byte_i,
    input wire logic tx_valid_i,
    output logic op_valid_o,
    output logic [7:0] op_o,
    output logic addr_valid_o,
    output logic [23:0] addr_o,
    output logic wdata_valid_o,
    output logic [7:0] wdata_o,
    output logic byte_req_o,
    output logic frame_end_o,
    output logic boundary_ok_o,
    output logic write_req_o
);
    logic [7:0] got [0:63];
    logic [63:0] got_v;
    initial begin
        {op_valid_o, addr_valid_o, wdata_valid_o, byte_req_o} = 4'h0;
        {frame_end_o, boundary_ok_o, write_req_o} = 3'h0;
        {op_o, wdata_o, addr_o} = 40'h0;
    end
    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask : tick
    // idle lines show the inverse of the last value
    task automatic frame(input logic [7:0] op, input logic [23:0] a, input bit use_a,
                         input bit nw, input logic [7:0] d, input int nr, input logic bok);
        op_o = op;
        op_valid_o = 1'b1;
        tick();
        op_valid_o = 1'b0;
        op_o = ~op;
        if (use_a) begin
            addr_o = a;
            addr_valid_o = 1'b1;
            tick();
            addr_valid_o = 1'b0;
            addr_o = ~a;
            tick();
        end
        if (nw) begin
            wdata_o = d;
            wdata_valid_o = 1'b1;
            tick();
            wdata_valid_o = 1'b0;
            wdata_o = ~d;
        end
        byte_req_o = (nr > 0);
        for (int i = 0; i < nr; i++) begin
            tick();
            got[i] = tx_byte_i;
            got_v[i] = tx_valid_i;
        end
        byte_req_o = 1'b0;
        frame_end_o = 1'b1;
        boundary_ok_o = bok;
        tick();
        frame_end_o = 1'b0;
        boundary_ok_o = ~bok;
    endtask : frame
    task automatic wreq();
        write_req_o = 1'b1;
        tick();
        write_req_o = 1'b0;
    endtask : wreq
endmodule : host_frontend_model

// >>> testbench/secured_otp_and_discovery_table_tb_top.sv
// self-checking bench for otp mode, security flags and discovery table reads
`timescale 1ns/1ps
module secured_otp_and_discovery_table_tb_top;
    import otp_sfdp_pkg::*;
    localparam logic [287:0] TABLE = {144'he520f1ffffffff0344eb086b083b80bbfeff,
                                      144'hffffffff00ffffff44eb0c200f5210d800ff};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic fac = 1'b0;
    logic nvl = 1'b0;
    logic op_v, a_v, w_v, b_req, f_end, bok, w_req, tx_v;
    logic otp_mode, array_we, otp_we, w_acc, w_deny, sr_go, rej, nv_prog;
    logic [7:0] op, wd, sec, tx;
    logic [23:0] addr;
    int n_fail = 0;
    int checks = 0;
    always #5 clk = ~clk;
    host_frontend_model host_frontend_model_i (.clk_i(clk), .tx_byte_i(tx), .tx_valid_i(tx_v),
        .op_valid_o(op_v), .op_o(op), .addr_valid_o(a_v), .addr_o(addr), .wdata_valid_o(w_v),
        .wdata_o(wd), .byte_req_o(b_req), .frame_end_o(f_end), .boundary_ok_o(bok),
        .write_req_o(w_req));
    secured_otp_ctrl secured_otp_ctrl_i (.SYS_CLK_I(clk), .RST_N_I(rst_n),
        .OPCODE_VALID_I(op_v), .OPCODE_I(op), .ADDR_VALID_I(a_v), .ADDR_I(addr),
        .WDATA_VALID_I(w_v), .WDATA_I(wd), .BYTE_REQ_I(b_req), .FRAME_END_I(f_end),
        .BOUNDARY_OK_I(bok), .WRITE_REQ_I(w_req), .FACTORY_LOCK_I(fac), .NV_LOCK_I(nvl),
        .OTP_MODE_O(otp_mode), .ARRAY_WRITE_EN_O(array_we), .OTP_WRITE_EN_O(otp_we),
        .WRITE_ACCEPT_O(w_acc), .WRITE_DENY_O(w_deny), .SR_WRITE_GO_O(sr_go),
        .CMD_REJECT_O(rej), .NV_LOCK_PROG_O(nv_prog), .SEC_REG_O(sec), .TX_BYTE_O(tx),
        .TX_VALID_O(tx_v));
    function automatic logic [7:0] disc_exp(input logic [23:0] a);
        if (a >= 24'h000080 && a <= 24'h0000a3) begin
            return TABLE[(24'h0000a3 - a) * 8 +: 8];
        end
        return DISC_BLANK;
    endfunction : disc_exp
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic results();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    task automatic do_reset(input logic f, input logic n);
        fac = f;
        nvl = n;
        rst_n = 1'b0;
        repeat (4) host_frontend_model_i.tick();
        rst_n = 1'b1;
        repeat (2) host_frontend_model_i.tick();
    endtask : do_reset
    // sec reads twice in one frame, both bytes checked against the expected value
    task automatic sec_read(input logic [7:0] exp);
        host_frontend_model_i.frame(OP_READ_SEC, 24'h0, 0, 0, 8'h00, 2, 1'b1);
        chk(host_frontend_model_i.got[0], exp);
        chk(host_frontend_model_i.got[1], exp);
    endtask : sec_read
    task automatic cmd(input logic [7:0] o, input bit nw, input logic [7:0] d, input logic b);
        host_frontend_model_i.frame(o, 24'h0, 0, nw, d, 0, b);
    endtask : cmd
    initial begin
        #100000;
        n_fail++;
        results();
    end
    initial begin
        do_reset(1'b0, 1'b0);
        chk(8'({otp_mode, array_we, otp_we}), 8'h02);
        chk(sec, 8'h00);
        host_frontend_model_i.frame(OP_READ_DISC, 24'h00007e, 1, 0, 8'h00, 40, 1'b1);
        for (int i = 0; i < 40; i++) begin
            chk(host_frontend_model_i.got[i], disc_exp(24'h00007e + i));
        end
        chk(host_frontend_model_i.got_v[39:32], 8'hff);
        host_frontend_model_i.frame(OP_READ_DISC, 24'h000089, 1, 0, 8'h00, 2, 1'b1);
        chk(host_frontend_model_i.got[1], 8'h08);
        host_frontend_model_i.frame(OP_READ_DISC, 24'h0000fe, 1, 0, 8'h00, 3, 1'b1);
        chk(host_frontend_model_i.got[2], 8'hff);
        $display("test discovery done");
        host_frontend_model_i.wreq();
        chk(8'({w_acc, w_deny}), 8'h02);
        cmd(OP_ENTER_OTP, 0, 8'h00, 1'b1);
        chk(8'({otp_mode, array_we, otp_we}), 8'h05);
        host_frontend_model_i.wreq();
        chk(8'({w_acc, w_deny}), 8'h02);
        cmd(8'h01, 0, 8'h00, 1'b1);
        chk(8'({rej, sr_go}), 8'h02);
        cmd(8'h31, 0, 8'h00, 1'b1);
        chk(8'({rej, sr_go}), 8'h02);
        cmd(OP_WRITE_SEC, 1, 8'h02, 1'b1);
        chk(8'({rej, nv_prog}), 8'h02);
        sec_read(8'h00);
        cmd(OP_LEAVE_OTP, 0, 8'h00, 1'b1);
        chk(8'({otp_mode, array_we}), 8'h01);
        cmd(8'h31, 0, 8'h00, 1'b1);
        chk(8'({rej, sr_go}), 8'h01);
        cmd(OP_WRITE_SEC, 1, 8'h02, 1'b0);
        chk(8'({rej, nv_prog}), 8'h00);
        cmd(OP_WRITE_SEC, 1, 8'hfe, 1'b1);
        chk(8'({rej, nv_prog}), 8'h01);
        sec_read(8'h02);
        $display("test modes done");
        for (int k = 1; k <= 2; k++) begin
            do_reset(k[0], k[1]);
            chk(sec, 8'(k));
            cmd(OP_ENTER_OTP, 0, 8'h00, 1'b1);
            chk(8'({otp_mode, otp_we}), 8'h02);
            host_frontend_model_i.wreq();
            chk(8'({w_acc, w_deny}), 8'h01);
            sec_read(8'(k));
            cmd(OP_LEAVE_OTP, 0, 8'h00, 1'b1);
        end
        $display("test locks done");
        results();
    end
endmodule : secured_otp_and_discovery_table_tb_top
